// [hw/hsib_pkg.sv]
// package: register map, field positions, reset values and carrier types of the status bank
package hsib_pkg;

  // register offsets
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
  localparam logic [7:0] ADDR_LIVE_STATUS = 8'h01;
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h02;
  localparam logic [7:0] ADDR_EVENT_MASK = 8'h03;
  localparam logic [7:0] ADDR_STATE_READBACK = 8'h3f;
  localparam logic [7:0] ADDR_MEASURE_A = 8'h4f;
  localparam logic [7:0] ADDR_MEASURE_B = 8'h50;
  localparam logic [7:0] ADDR_MEASURE_C = 8'h51;
  localparam logic [7:0] ADDR_CHIP_ID_HIGH = 8'h57;
  localparam logic [7:0] ADDR_CHIP_ID_LOW = 8'h58;

  // status, flag and mask bit positions
  localparam int BIT_UNDERVOLTAGE = 5;
  localparam int BIT_FIFO_LOW = 4;
  localparam int BIT_FIFO_HIGH = 3;
  localparam int BIT_OVERCURRENT = 2;
  localparam int BIT_OVERTEMP = 1;
  localparam int BIT_PLAYBACK_FINISHED = 0;
  localparam logic [7:0] EVENT_BITS = 8'h3f;
  localparam logic [7:0] MASK_UNUSED_ONES = 8'hc0;

  // values after reset, and the code that triggers a software reset
  localparam logic [7:0] SOFT_RESET_RESET = 8'h00;
  localparam logic [7:0] LIVE_STATUS_RESET = 8'h10;
  localparam logic [7:0] EVENT_FLAGS_RESET = 8'h10;
  localparam logic [7:0] EVENT_MASK_RESET = 8'hff;
  localparam logic [7:0] SOFTWARE_RESET_CODE = 8'haa;

  // plain read/write configuration registers with their defaults
  localparam int CFG_COUNT = 20;
  localparam logic [CFG_COUNT-1:0][7:0] CFG_ADDRS = {
    8'h5d, 8'h56, 8'h53, 8'h52, 8'h4e, 8'h4d, 8'h4c, 8'h4b, 8'h4a, 8'h49,
    8'h48, 8'h47, 8'h46, 8'h45, 8'h44, 8'h43, 8'h42, 8'h41, 8'h40, 8'h3e};
  localparam logic [CFG_COUNT-1:0][7:0] CFG_DEFAULTS = {
    8'h00, 8'h03, 8'h08, 8'h00, 8'h04, 8'h24, 8'h00, 8'h32, 8'hbf, 8'h28,
    8'ha0, 8'h00, 8'h88, 8'h0a, 8'h28, 8'h80, 8'h00, 8'h00, 8'h00, 8'h1b};

  // serial bus figures
  localparam logic [6:0] DEVICE_ADDR_DEFAULT = 7'h5a;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    HSIB_IDLE = 4'b0000,
    HSIB_ADDR = 4'b0001,
    HSIB_ADDR_ACK = 4'b0010,
    HSIB_REG = 4'b0011,
    HSIB_REG_ACK = 4'b0100,
    HSIB_WDATA = 4'b0101,
    HSIB_WDATA_ACK = 4'b0110,
    HSIB_RDATA = 4'b0111,
    HSIB_RACK = 4'b1000
  } hsib_bus_state_type;

  // live conditions reported by the rest of the device
  typedef struct packed {
    logic undervoltage_live;
    logic fifo_low_live;
    logic fifo_high_live;
    logic overcurrent_live;
    logic overtemp_live;
    logic playback_finished_live;
  } hsib_live_type;

  // serial bus pins as seen by the block
  typedef struct packed {
    logic scl;
    logic sda;
  } hsib_bus_pins_type;

endpackage : hsib_pkg

// [hw/hsib_status_bank.sv]
// status, flag and mask registers of the haptic driver with its serial register port
//
// What this block does
// - writing 0xaa to soft reset returns every configuration register to default
// - status bit 5 shows supply presently below undervoltage threshold
// - status bit 4 shows streaming fifo almost empty; reads 1 after reset
// - status bit 3 shows streaming fifo presently almost full
// - status bit 2 shows an overcurrent condition in progress
// - status bit 1 shows an overtemperature condition in progress
// - status bit 0 shows playback finished and device heading to standby
// - flags 5..0 latch their status bit since last read; reading clears them
// - a latched flag pulls the interrupt low only when its mask is 0
// - after reset all six masks are 1 and upper two mask bits read 1
// - after reset only fifo-low flag is 1; upper two flag bits read 0
`timescale 1ns/1ps
`default_nettype none

module hsib_status_bank #(
  parameter logic [6:0] DEVICE_ADDR = hsib_pkg::DEVICE_ADDR_DEFAULT,
  // arbitrary identification values
  parameter logic [7:0] CHIP_ID_HIGH = 8'h5c,
  parameter logic [7:0] CHIP_ID_LOW = 8'h21
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // live conditions
  input wire hsib_pkg::hsib_live_type live_in,
  // serial register port, open drain data
  input wire hsib_pkg::hsib_bus_pins_type bus_in,
  output logic sda_out,
  output logic sda_oe_out,
  // interrupt pin and configuration view
  output logic irq_out_n,
  output logic [hsib_pkg::CFG_COUNT-1:0][7:0] cfg_out
);

  typedef struct packed {
    logic scl_q;
    logic sda_q;
    hsib_pkg::hsib_bus_state_type state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic nack;
    logic sda_low;
    logic sda_oe;
    logic [7:0] soft_reset;
    logic [7:0] live;
    logic [7:0] flags;
    logic [7:0] mask;
    logic [hsib_pkg::CFG_COUNT-1:0][7:0] cfg;
    logic irq_n;
  } hsib_state_type;

  hsib_state_type st_reg;
  hsib_state_type st_next;

  // write and read-load strobes, also watched by the checks
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_load;
  logic [7:0] rd_addr;

  function automatic logic [5:0] cfg_lookup(input logic [7:0] addr);
    logic [5:0] res;
    res = 6'h3f;
    for (int i = 0; i < hsib_pkg::CFG_COUNT; i++) begin
      if (hsib_pkg::CFG_ADDRS[i] == addr) begin
        res = 6'(i);
      end
    end
    return res;
  endfunction : cfg_lookup

  function automatic logic [7:0] read_value(input hsib_state_type s, input logic [7:0] addr);
    logic [7:0] val;
    logic [5:0] idx;
    val = 8'h00;
    idx = cfg_lookup(addr);
    if (addr == hsib_pkg::ADDR_SOFT_RESET) begin
      val = s.soft_reset;
    end else if (addr == hsib_pkg::ADDR_LIVE_STATUS) begin
      val = s.live;
    end else if (addr == hsib_pkg::ADDR_EVENT_FLAGS) begin
      val = s.flags;
    end else if (addr == hsib_pkg::ADDR_EVENT_MASK) begin
      val = s.mask;
    end else if (addr == hsib_pkg::ADDR_CHIP_ID_HIGH) begin
      val = CHIP_ID_HIGH;
    end else if (addr == hsib_pkg::ADDR_CHIP_ID_LOW) begin
      val = CHIP_ID_LOW;
    end else if (idx != 6'h3f) begin
      val = s.cfg[idx[4:0]];
    end
    // engine readbacks and unmapped locations read zero
    return val;
  endfunction : read_value

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise = bus_in.scl & ~st_reg.scl_q;
  assign scl_fall = ~bus_in.scl & st_reg.scl_q;
  assign start_cond = bus_in.scl & st_reg.scl_q & st_reg.sda_q & ~bus_in.sda;
  assign stop_cond = bus_in.scl & st_reg.scl_q & ~st_reg.sda_q & bus_in.sda;

  always_comb begin
    logic [7:0] rd_byte;
    logic [5:0] widx;
    logic [7:0] raw_live;
    st_next = st_reg;
    wr_en = 1'b0;
    wr_addr = st_reg.ptr;
    wr_data = st_reg.shift;
    rd_load = 1'b0;
    rd_addr = st_reg.ptr;
    rd_byte = 8'h00;
    widx = 6'h3f;
    raw_live = 8'h00;
    st_next.scl_q = bus_in.scl;
    st_next.sda_q = bus_in.sda;
    st_next.sda_low = 1'b0;

    // serial protocol: sample on scl rise, change data on scl fall
    // start and stop outrank scl edges, so a repeated start recovers from any state
    if (start_cond) begin
      st_next.state = hsib_pkg::HSIB_ADDR;
      st_next.bit_cnt = 4'h0;
      st_next.sda_oe = 1'b0;
    end else if (stop_cond) begin
      st_next.state = hsib_pkg::HSIB_IDLE;
      st_next.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (st_reg.state)
        hsib_pkg::HSIB_ADDR, hsib_pkg::HSIB_REG, hsib_pkg::HSIB_WDATA: begin
          st_next.shift = {st_reg.shift[6:0], bus_in.sda};
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
        end
        hsib_pkg::HSIB_RDATA: begin
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
        end
        hsib_pkg::HSIB_RACK: begin
          st_next.nack = bus_in.sda;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st_reg.state)
        hsib_pkg::HSIB_ADDR: begin
          if (st_reg.bit_cnt == hsib_pkg::BITS_PER_BYTE) begin
            if (st_reg.shift[7:1] == DEVICE_ADDR) begin
              st_next.state = hsib_pkg::HSIB_ADDR_ACK;
              st_next.nack = st_reg.shift[0];
              st_next.sda_oe = 1'b1;
            end else begin
              // another device is addressed; stay off the bus until the next start
              st_next.state = hsib_pkg::HSIB_IDLE;
            end
          end
        end
        hsib_pkg::HSIB_ADDR_ACK: begin
          st_next.bit_cnt = 4'h0;
          if (st_reg.nack) begin
            // read direction: the nack field held the direction bit here
            rd_load = 1'b1;
            rd_byte = read_value(st_reg, st_reg.ptr);
            st_next.shift = rd_byte;
            st_next.sda_oe = ~rd_byte[7];
            st_next.ptr = st_reg.ptr + 8'h01;
            st_next.state = hsib_pkg::HSIB_RDATA;
          end else begin
            st_next.sda_oe = 1'b0;
            st_next.state = hsib_pkg::HSIB_REG;
          end
        end
        hsib_pkg::HSIB_REG: begin
          if (st_reg.bit_cnt == hsib_pkg::BITS_PER_BYTE) begin
            st_next.ptr = st_reg.shift;
            st_next.sda_oe = 1'b1;
            st_next.state = hsib_pkg::HSIB_REG_ACK;
          end
        end
        hsib_pkg::HSIB_WDATA: begin
          if (st_reg.bit_cnt == hsib_pkg::BITS_PER_BYTE) begin
            wr_en = 1'b1;
            st_next.ptr = st_reg.ptr + 8'h01;
            st_next.sda_oe = 1'b1;
            st_next.state = hsib_pkg::HSIB_WDATA_ACK;
          end
        end
        hsib_pkg::HSIB_REG_ACK, hsib_pkg::HSIB_WDATA_ACK: begin
          st_next.sda_oe = 1'b0;
          st_next.bit_cnt = 4'h0;
          st_next.state = hsib_pkg::HSIB_WDATA;
        end
        hsib_pkg::HSIB_RDATA: begin
          if (st_reg.bit_cnt == hsib_pkg::BITS_PER_BYTE) begin
            st_next.sda_oe = 1'b0;
            st_next.state = hsib_pkg::HSIB_RACK;
          end else begin
            // bit 7 went out at load; each fall presents the next lower bit
            st_next.shift = {st_reg.shift[6:0], 1'b0};
            st_next.sda_oe = ~st_reg.shift[6];
          end
        end
        hsib_pkg::HSIB_RACK: begin
          if (st_reg.nack) begin
            // master is done; wait for stop or repeated start
            st_next.state = hsib_pkg::HSIB_IDLE;
          end else begin
            rd_load = 1'b1;
            rd_byte = read_value(st_reg, st_reg.ptr);
            st_next.shift = rd_byte;
            st_next.sda_oe = ~rd_byte[7];
            st_next.ptr = st_reg.ptr + 8'h01;
            st_next.bit_cnt = 4'h0;
            st_next.state = hsib_pkg::HSIB_RDATA;
          end
        end
        default: begin
        end
      endcase
    end

    // register writes; the host keeps off reserved locations, so they are dropped
    widx = cfg_lookup(wr_addr);
    if (wr_en) begin
      if (wr_addr == hsib_pkg::ADDR_SOFT_RESET) begin
        st_next.soft_reset = wr_data;
        if (wr_data == hsib_pkg::SOFTWARE_RESET_CODE) begin
          st_next.soft_reset = hsib_pkg::SOFT_RESET_RESET;
          st_next.mask = hsib_pkg::EVENT_MASK_RESET;
          st_next.cfg = hsib_pkg::CFG_DEFAULTS;
        end
      end else if (wr_addr == hsib_pkg::ADDR_EVENT_MASK) begin
        st_next.mask = wr_data | hsib_pkg::MASK_UNUSED_ONES;
      end else if (widx != 6'h3f) begin
        st_next.cfg[widx[4:0]] = wr_data;
      end
    end

    // live status mirrors the conditions, one cycle behind
    raw_live[hsib_pkg::BIT_UNDERVOLTAGE] = live_in.undervoltage_live;
    raw_live[hsib_pkg::BIT_FIFO_LOW] = live_in.fifo_low_live;
    raw_live[hsib_pkg::BIT_FIFO_HIGH] = live_in.fifo_high_live;
    raw_live[hsib_pkg::BIT_OVERCURRENT] = live_in.overcurrent_live;
    raw_live[hsib_pkg::BIT_OVERTEMP] = live_in.overtemp_live;
    raw_live[hsib_pkg::BIT_PLAYBACK_FINISHED] = live_in.playback_finished_live;
    st_next.live = raw_live;

    // flags clear when loaded for transmit; a condition in the same cycle still sets
    if (rd_load && rd_addr == hsib_pkg::ADDR_EVENT_FLAGS) begin
      st_next.flags = 8'h00;
    end
    st_next.flags = (st_next.flags | st_reg.live) & hsib_pkg::EVENT_BITS;

    // irq is built from the next flags and mask so it never trails the flags by a cycle
    st_next.irq_n = ~|(st_next.flags & ~st_next.mask & hsib_pkg::EVENT_BITS);
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '{
        scl_q: 1'b1,
        sda_q: 1'b1,
        state: hsib_pkg::HSIB_IDLE,
        bit_cnt: 4'h0,
        shift: 8'h00,
        ptr: 8'h00,
        nack: 1'b0,
        sda_low: 1'b0,
        sda_oe: 1'b0,
        soft_reset: hsib_pkg::SOFT_RESET_RESET,
        live: hsib_pkg::LIVE_STATUS_RESET,
        flags: hsib_pkg::EVENT_FLAGS_RESET,
        mask: hsib_pkg::EVENT_MASK_RESET,
        cfg: hsib_pkg::CFG_DEFAULTS,
        irq_n: 1'b1
      };
    end else begin
      st_reg <= st_next;
    end
  end

  assign sda_out = st_reg.sda_low;
  assign sda_oe_out = st_reg.sda_oe;
  assign irq_out_n = st_reg.irq_n;
  assign cfg_out = st_reg.cfg;

  // checks
  a_soft_reset_mask: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en && wr_addr == 8'h00 && wr_data == 8'haa
    |=> st_reg.mask == 8'hff && st_reg.cfg == hsib_pkg::CFG_DEFAULTS)
    else $error("soft reset code did not restore defaults");

  a_live_undervolt: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    live_in.undervoltage_live |=> st_reg.live[5])
    else $error("undervoltage status not mirrored");

  a_live_fifo_low: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    st_reg.live[4] == $past(live_in.fifo_low_live) || $past(!rst_n_in))
    else $error("fifo low status not mirrored");

  a_live_fifo_high: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !live_in.fifo_high_live |=> !st_reg.live[3])
    else $error("fifo high status stuck");

  a_live_overcurrent: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    live_in.overcurrent_live |=> st_reg.live[2] ##1 st_reg.flags[2])
    else $error("overcurrent status or flag missing");

  a_live_overtemp: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(live_in.overtemp_live) |=> $rose(st_reg.live[1]))
    else $error("overtemperature status not mirrored");

  a_live_done: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    live_in.playback_finished_live [*2] |-> ##1 st_reg.live[0] && st_reg.flags[0])
    else $error("playback finished status not mirrored");

  a_flag_sticky: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    st_reg.flags[5] && !(rd_load && rd_addr == 8'h02) |=> st_reg.flags[5])
    else $error("flag dropped without a read");

  a_flag_read_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_load && rd_addr == 8'h02 && st_reg.live == 8'h00 |=> st_reg.flags == 8'h00)
    else $error("flag read did not clear");

  a_irq_gating: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    irq_out_n == !(|(st_reg.flags & ~st_reg.mask & 8'h3f)))
    else $error("interrupt pin disagrees with flags and mask");

  a_mask_upper: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    st_reg.mask[7:6] == 2'b11)
    else $error("upper mask bits not ones");

  a_flag_upper: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    st_reg.flags[7:6] == 2'b00)
    else $error("upper flag bits not zero");

  a_irq_release: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !irq_out_n && rd_load && rd_addr == 8'h02 && st_reg.live == 8'h00 |=> irq_out_n)
    else $error("interrupt not released after flag read");

  a_flag_latch: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (st_reg.flags & $past(st_reg.live)) == $past(st_reg.live))
    else $error("live condition not latched into its flag");

  a_mask_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en && wr_addr == 8'h03 |=> st_reg.mask == ($past(wr_data) | 8'hc0))
    else $error("mask write not stored with upper bits set");

  a_irq_open: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (st_reg.live & ~st_reg.mask & 8'h3f) != 8'h00 && !wr_en |=> !irq_out_n)
    else $error("unmasked condition did not pull the interrupt low");

  a_irq_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (st_reg.flags & ~st_reg.mask & 8'h3f) == 8'h00 && st_reg.live == 8'h00 && !wr_en
    |=> irq_out_n)
    else $error("interrupt low with nothing unmasked pending");

  a_cfg_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !wr_en |=> st_reg.cfg == $past(st_reg.cfg))
    else $error("configuration changed without a write");

  a_soft_reset_flags: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en && wr_addr == 8'h00
    |=> st_reg.flags == (($past(st_reg.flags) | $past(st_reg.live)) & 8'h3f))
    else $error("soft reset disturbed the event flags");

endmodule : hsib_status_bank

`default_nettype wire

// [test/hsib_host_model.sv]
// host side model: i2c bus master that reaches the status bank registers
`timescale 1ns/1ps
`default_nettype none

module hsib_host_model #(
  parameter logic [6:0] ADDR = 7'h5a,
  parameter int Q = 4
) (
  // clock and wire level
  input wire logic clk_in,
  input wire logic sda_in,
  // bus drive, sda only ever pulled low
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic gap;
    repeat (Q) @(negedge clk_in);
  endtask : gap

  // data moves only while scl is low, so the device never sees a false start or stop
  task automatic put_bit(input logic b, output logic r);
    sda_low_out = !b;
    gap();
    scl_out = 1'b1;
    gap();
    r = sda_in;
    scl_out = 1'b0;
    gap();
  endtask : put_bit

  task automatic put_byte(input logic [7:0] d, input logic mack, output logic [7:0] r,
      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], r[i]);
    end
    put_bit(mack, ack);
  endtask : put_byte

  // also serves as repeated start: sda is released while scl is still low
  task automatic s_cond;
    sda_low_out = 1'b0;
    gap();
    scl_out = 1'b1;
    gap();
    sda_low_out = 1'b1;
    gap();
    scl_out = 1'b0;
    gap();
  endtask : s_cond

  task automatic p_cond;
    sda_low_out = 1'b1;
    gap();
    scl_out = 1'b1;
    gap();
    sda_low_out = 1'b0;
    gap();
  endtask : p_cond

  // callers only name mapped locations, reserved ones are never written
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ack);
    logic [7:0] r;
    logic k1;
    logic k2;
    logic k3;
    s_cond();
    put_byte({ADDR, 1'b0}, 1'b1, r, k1);
    put_byte(a, 1'b1, r, k2);
    put_byte(d, 1'b1, r, k3);
    p_cond();
    ack = k1 | k2 | k3;
  endtask : write_reg

  // single byte read, ended by a nack
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] r;
    logic k;
    s_cond();
    put_byte({ADDR, 1'b0}, 1'b1, r, k);
    put_byte(a, 1'b1, r, k);
    s_cond();
    put_byte({ADDR, 1'b1}, 1'b1, r, k);
    put_byte(8'hff, 1'b1, d, k);
    p_cond();
  endtask : read_reg

  // two-byte read: the first byte is acked so the pointer moves on
  task automatic read_pair(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
    logic [7:0] r;
    logic k;
    s_cond();
    put_byte({ADDR, 1'b0}, 1'b1, r, k);
    put_byte(a, 1'b1, r, k);
    s_cond();
    put_byte({ADDR, 1'b1}, 1'b1, r, k);
    put_byte(8'hff, 1'b0, d0, k);
    put_byte(8'hff, 1'b1, d1, k);
    p_cond();
  endtask : read_pair
endmodule : hsib_host_model
`default_nettype wire

// [test/testbench.sv]
// bench: host model reaches the status bank; expectations queued and checked by a monitor
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // arbitrary identification value
  localparam logic [7:0] ID_HIGH = 8'h3c;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  hsib_pkg::hsib_live_type live = 6'h10;
  hsib_pkg::hsib_bus_pins_type bus;
  logic scl;
  logic host_low;
  logic sda_oe;
  logic sda_lvl;
  logic irq_n;
  logic [hsib_pkg::CFG_COUNT-1:0][7:0] cfg;
  logic [7:0] exp_q[$];
  logic [7:0] seen;
  logic [7:0] rd;
  logic [7:0] v;
  logic ack;
  int idx;
  int err_count = 0;
  int tests_run = 0;
  integer seed = 32'h5ecbc7e7;
  event got;

  initial begin
    forever #5 ref_clk = !ref_clk;
  end

  // sda has a pull-up; while enabled the device puts its data level on the wire
  assign bus = {scl, !host_low & (!sda_oe | sda_lvl)};

  hsib_status_bank #(.CHIP_ID_HIGH(ID_HIGH)) i_hsib_status_bank (
    .ref_clk_in(ref_clk), .rst_n_in(rst_n), .live_in(live), .bus_in(bus), .sda_out(sda_lvl),
    .sda_oe_out(sda_oe), .irq_out_n(irq_n), .cfg_out(cfg));

  hsib_host_model i_hsib_host_model (
    .clk_in(ref_clk), .sda_in(bus.sda), .scl_out(scl), .sda_low_out(host_low));

  task automatic check(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check

  // one edge passes after each note so the monitor never misses an event
  task automatic note(input logic [7:0] e, input logic [7:0] s);
    exp_q.push_back(e);
    seen = s;
    -> got;
    @(negedge ref_clk);
  endtask : note

  task automatic expect_rd(input logic [7:0] a, input logic [7:0] e);
    i_hsib_host_model.read_reg(a, rd);
    note(e, rd);
  endtask : expect_rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_hsib_host_model.write_reg(a, d, ack);
    note(8'h00, {7'h0, ack});
  endtask : wr

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    forever begin
      @(got);
      check(seen, exp_q.pop_front());
    end
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    err_count++;
    print_verdict();
  end

  initial begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    note(8'h01, {7'h0, irq_n});
    expect_rd(hsib_pkg::ADDR_LIVE_STATUS, 8'h10);
    expect_rd(hsib_pkg::ADDR_EVENT_FLAGS, 8'h10);
    expect_rd(hsib_pkg::ADDR_EVENT_MASK, 8'hff);
    live = 6'h00;
    repeat (3) @(negedge ref_clk);
    // the condition stayed live through the clearing read, so the flag came back
    expect_rd(hsib_pkg::ADDR_EVENT_FLAGS, 8'h10);
    expect_rd(hsib_pkg::ADDR_EVENT_FLAGS, 8'h00);
    for (int k = 0; k < 10; k++) begin
      v = (k < 6) ? 8'(8'h01 << k) : (8'($random(seed)) & 8'h3f);
      live = v[5:0];
      expect_rd(hsib_pkg::ADDR_LIVE_STATUS, v);
      live = 6'h00;
      repeat (3) @(negedge ref_clk);
      expect_rd(hsib_pkg::ADDR_EVENT_FLAGS, v);
      expect_rd(hsib_pkg::ADDR_EVENT_FLAGS, 8'h00);
    end
    wr(hsib_pkg::ADDR_EVENT_MASK, 8'h00);
    expect_rd(hsib_pkg::ADDR_EVENT_MASK, 8'hc0);
    note(8'h01, {7'h0, irq_n});
    // a one-cycle overcurrent pulse must still be caught
    live = 6'h04;
    @(negedge ref_clk);
    live = 6'h00;
    repeat (3) @(negedge ref_clk);
    note(8'h00, {7'h0, irq_n});
    wr(hsib_pkg::ADDR_EVENT_MASK, 8'h04);
    note(8'h01, {7'h0, irq_n});
    wr(hsib_pkg::ADDR_EVENT_MASK, 8'h3b);
    note(8'h00, {7'h0, irq_n});
    expect_rd(hsib_pkg::ADDR_EVENT_FLAGS, 8'h04);
    note(8'h01, {7'h0, irq_n});
    // acked burst: the flag byte, then the mask byte from the advanced pointer
    live = 6'h24;
    repeat (3) @(negedge ref_clk);
    live = 6'h00;
    repeat (3) @(negedge ref_clk);
    note(8'h00, {7'h0, irq_n});
    i_hsib_host_model.read_pair(hsib_pkg::ADDR_EVENT_FLAGS, rd, v);
    note(8'h24, rd);
    note(8'hfb, v);
    note(8'h01, {7'h0, irq_n});
    for (int k = 0; k < 3; k++) begin
      idx = $unsigned($random(seed)) % hsib_pkg::CFG_COUNT;
      v = 8'($random(seed));
      wr(hsib_pkg::CFG_ADDRS[idx], v);
      expect_rd(hsib_pkg::CFG_ADDRS[idx], v);
      note(v, cfg[idx]);
    end
    wr(hsib_pkg::ADDR_EVENT_MASK, 8'h15);
    wr(hsib_pkg::ADDR_SOFT_RESET, hsib_pkg::SOFTWARE_RESET_CODE);
    for (int k = 0; k < hsib_pkg::CFG_COUNT; k++) begin
      note(hsib_pkg::CFG_DEFAULTS[k], cfg[k]);
    end
    expect_rd(hsib_pkg::ADDR_EVENT_MASK, 8'hff);
    expect_rd(hsib_pkg::ADDR_SOFT_RESET, 8'h00);
    expect_rd(hsib_pkg::ADDR_CHIP_ID_HIGH, ID_HIGH);
    // second reset in mid-run with the bus idle
    wr(hsib_pkg::ADDR_EVENT_MASK, 8'h00);
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    note(8'h01, {7'h0, irq_n});
    expect_rd(hsib_pkg::ADDR_EVENT_MASK, 8'hff);
    expect_rd(hsib_pkg::ADDR_EVENT_FLAGS, 8'h10);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
